// ### logic/trib_cmd_decoder.sv
// Purpose: Decodes host control commands for tributary polling and slots
// Assumes: Command bytes are stable while cmdValid is high for one cycle
// Notes:   Common pool quota arithmetic is outside this block
//
// Summary of operation
// - Unlatch flag forces addressed tributary active and returns it to the algorithm.
// - Latch flag fixes polling state to parameter byte bits one and zero.
// - Polling field: 00 active, 01 inactive, 10 unresponsive, 11 dead.
// - Key 00 creates no slot; it completes and hands the command registers back.
// - Pool and latch flags are acted on even with the null key.
// - Key 01 creates a status slot for the addressed tributary.
// - Twelve status slots, each sixty-four byte locations.
// - Global status slot exists once any tributary is established.
// - Pool and latch flags combine with establish in one command.
// - Target address always comes from the tributary address byte.
`timescale 1ns/1ps
module trib_cmd_decoder #(
   parameter int SLOTS = trib_cmd_pkg::SLOT_COUNT,
   parameter int DEPTH = trib_cmd_pkg::SLOT_DEPTH
) (
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   input  wire logic                          cmdValid,
   input  wire logic [2:0]                    requestKey,
   input  wire logic [7:0]                    tributaryAddressByte,
   input  wire logic [7:0]                    commandParameterByte,
   input  wire logic [15:0]                   controlFlagByte,
   input  wire logic [3:0]                    statusSlotSel,
   input  wire logic [trib_cmd_pkg::LOC_ADDR_W-1:0] statusLocSel,
   output logic                               cmdDone,
   output logic                               procError,
   output logic                               unknownKey,
   output logic                               globalSlotValid,
   output logic [SLOTS-1:0]                   slotUsed,
   output logic [2*SLOTS-1:0]                 pollState,
   output logic [SLOTS-1:0]                   pollLatched,
   output logic [SLOTS-1:0]                   poolEnabled,
   output logic [7:0]                         statusByte
);
   import trib_cmd_pkg::*;

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   wire       isNull      = (requestKey == KEY_NULL);
   wire       isEstablish = (requestKey == KEY_ESTABLISH);
   wire       flagUnlatch = controlFlagByte[FLAG_UNLATCH];
   wire       flagLatch   = controlFlagByte[FLAG_LATCH];
   wire       flagPoolEn  = controlFlagByte[FLAG_POOL_EN];
   wire       flagPoolDis = controlFlagByte[FLAG_POOL_DIS];
   wire [1:0] latchValue  = commandParameterByte[1:0];

   logic             hit;
   logic [3:0]       hitIdx;
   logic             freeAvail;
   logic [3:0]       freeIdx;
   logic [SLOTS-1:0] usedMap;

   // Address lookup always keyed by the tributary address byte
   trib_slot_table #(.SLOTS(SLOTS)) uTable (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .lookAddr  (tributaryAddressByte),
      .allocEn   (cmdValid && isEstablish),
      .hit       (hit),
      .hitIdx    (hitIdx),
      .freeAvail (freeAvail),
      .freeIdx   (freeIdx),
      .usedMap   (usedMap)
   );

   // Slot that flags act on: existing one, or one being created now
   wire       newSlot    = isEstablish && !hit && freeAvail;
   wire       targetOk   = hit || newSlot;
   wire [3:0] targetIdx  = hit ? hitIdx : freeIdx;
   wire       flagsAct   = cmdValid && targetOk;
   wire       estFull    = cmdValid && isEstablish && !hit && !freeAvail;
   wire       keyBad     = cmdValid && !isNull && !isEstablish;

   logic [1:0] poll_q [SLOTS];
   logic [SLOTS-1:0] latched_q;
   logic [SLOTS-1:0] pool_q;
   logic [7:0] mem_q [SLOTS][DEPTH];

   // ---------------------------------------------------------------
   // Per-slot polling, pool and status storage
   // ---------------------------------------------------------------
   genvar s;
   generate
      for (s = 0; s < SLOTS; s++) begin : gSlot
         wire sel = flagsAct && (targetIdx == 4'(s));
         // Latch wins over unlatch if host sets both
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               poll_q[s]    <= POLL_ACTIVE;
               latched_q[s] <= 1'b0;
            end else if (sel && flagLatch) begin
               poll_q[s]    <= latchValue;
               latched_q[s] <= 1'b1;
            end else if (sel && flagUnlatch) begin
               poll_q[s]    <= POLL_ACTIVE;
               latched_q[s] <= 1'b0;
            end else if (cmdValid && newSlot && freeIdx == 4'(s)) begin
               poll_q[s]    <= POLL_ACTIVE;
               latched_q[s] <= 1'b0;
            end
         end
         // Disable takes precedence so a conflicting command leaves pool off
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               pool_q[s] <= 1'b0;
            end else if (sel && flagPoolDis) begin
               pool_q[s] <= 1'b0;
            end else if (sel && flagPoolEn) begin
               pool_q[s] <= 1'b1;
            end else if (cmdValid && newSlot && freeIdx == 4'(s)) begin
               pool_q[s] <= 1'b0;
            end
         end
         // Status bytes wiped when a slot is (re)created
         for (genvar l = 0; l < DEPTH; l++) begin : gLoc
            always_ff @(posedge core_clk) begin
               if (!rst_n) begin
                  mem_q[s][l] <= SLOT_RESET_BYTE;
               end else if (cmdValid && newSlot && freeIdx == 4'(s)) begin
                  mem_q[s][l] <= SLOT_RESET_BYTE;
               end
            end
         end
         assign pollState[2*s +: 2] = poll_q[s];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Completion and status outputs
   // ---------------------------------------------------------------
   // Null key still completes, handing the command path back to the host
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cmdDone    <= 1'b0;
         procError  <= 1'b0;
         unknownKey <= 1'b0;
      end else begin
         cmdDone    <= cmdValid;
         procError  <= estFull;
         unknownKey <= keyBad;
      end
   end

   // Global slot appears with the first established tributary
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         globalSlotValid <= 1'b0;
      end else begin
         globalSlotValid <= |usedMap || (cmdValid && newSlot);
      end
   end

   // Registered mirrors so every output leaves a flip-flop
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         slotUsed    <= '0;
         pollLatched <= '0;
         poolEnabled <= '0;
         statusByte  <= 8'h00;
      end else begin
         slotUsed    <= usedMap;
         pollLatched <= latched_q;
         poolEnabled <= pool_q;
         statusByte  <= (statusSlotSel < 4'(SLOTS)) ? mem_q[statusSlotSel][statusLocSel] : 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   latch_sets_state_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      flagsAct && flagLatch |=> poll_q[$past(targetIdx)] == $past(latchValue))
      else $error("latched polling state not taken from parameter byte");
   unlatch_active_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      flagsAct && flagUnlatch && !flagLatch |=> poll_q[$past(targetIdx)] == POLL_ACTIVE)
      else $error("unlatch did not force active state");
   null_done_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      cmdValid && isNull |=> cmdDone && !procError)
      else $error("null command did not complete cleanly");
   establish_slot_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      cmdValid && newSlot |=> ##1 slotUsed[$past(freeIdx, 2)])
      else $error("establish did not claim a slot");
   full_reject_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      estFull |=> procError && $stable(usedMap))
      else $error("establish with full table not refused");
   global_slot_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      cmdValid && newSlot |=> globalSlotValid)
      else $error("global slot missing after establish");
   null_flags_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      cmdValid && isNull && hit && flagPoolEn && !flagPoolDis |=> pool_q[$past(hitIdx)])
      else $error("pool flag ignored with null key");
   combo_flags_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      cmdValid && newSlot && flagLatch |=> latched_q[$past(freeIdx)])
      else $error("latch flag ignored with establish");
   // A known address must never take a second slot, or the table would leak entries
   reestablish_keep_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      cmdValid && isEstablish && hit |=> $stable(usedMap))
      else $error("establish of a known address claimed another slot");
   // Completion is a pulse only for a command actually taken
   done_pulse_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      !cmdValid |=> !cmdDone)
      else $error("completion pulse without a command");
   // Flags naming an address with no slot must not touch any slot
   orphan_flags_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      cmdValid && !hit && !isEstablish |=> $stable(pollState) && $stable(pool_q))
      else $error("flags acted on an address without a slot");
   // No global slot while the table is empty and nothing is being created
   global_idle_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      !(|usedMap) && !(cmdValid && newSlot) |=> !globalSlotValid)
      else $error("global slot present with no tributary");
   // A refused establish leaves every slot's latch and pool state alone
   full_still_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      estFull |=> $stable(latched_q) && $stable(pool_q))
      else $error("refused establish changed slot state");
endmodule : trib_cmd_decoder

// ### include/trib_cmd_pkg.sv
// Purpose: Shared constants for the tributary control command decoder
// Assumes: Command fields arrive as separate bytes from the host command path
// Notes:   Flag positions are bit numbers within the control flag byte word
package trib_cmd_pkg;
   localparam int SLOT_COUNT     = 12;       // Tributary status slots
   localparam int SLOT_DEPTH     = 64;       // Byte locations per slot
   localparam int SLOT_IDX_W     = 4;
   localparam int LOC_ADDR_W     = 6;
   // Flag bit positions in the 16-bit control word
   localparam int FLAG_POOL_EN   = 8;
   localparam int FLAG_POOL_DIS  = 9;
   localparam int FLAG_UNLATCH   = 12;
   localparam int FLAG_LATCH     = 13;
   // Request keys
   localparam logic [2:0] KEY_NULL      = 3'h0;
   localparam logic [2:0] KEY_ESTABLISH = 3'h1;
   // Polling state encoding
   typedef enum logic [1:0] {
      POLL_ACTIVE       = 2'b00,
      POLL_INACTIVE     = 2'b01,
      POLL_UNRESPONSIVE = 2'b10,
      POLL_DEAD         = 2'b11
   } poll_state_type;
   localparam logic [7:0] SLOT_RESET_BYTE = 8'h00;
endpackage : trib_cmd_pkg

// ### logic/trib_slot_table.sv
// Purpose: Slot allocation table, one entry per tributary status slot
// Assumes: Single clock, synchronous active-low reset
// Notes:   Lookup is combinational; allocation picks the lowest free entry
`timescale 1ns/1ps
module trib_slot_table #(
   parameter int SLOTS = 12
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  lookAddr,
   input  wire logic        allocEn,
   output logic             hit,
   output logic [3:0]       hitIdx,
   output logic             freeAvail,
   output logic [3:0]       freeIdx,
   output logic [SLOTS-1:0] usedMap
);
   import trib_cmd_pkg::*;

   logic [SLOTS-1:0] used_q;
   logic [7:0]       addr_q [SLOTS];
   logic [SLOTS-1:0] matchVec;

   // ---------------------------------------------------------------
   // Per-entry storage and match
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : gEntry
         assign matchVec[g] = used_q[g] && (addr_q[g] == lookAddr);
         // Entry is claimed only when no hit and it is the chosen free one
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               used_q[g] <= 1'b0;
               addr_q[g] <= 8'h00;
            end else if (allocEn && !hit && freeAvail && freeIdx == 4'(g)) begin
               used_q[g] <= 1'b1;
               addr_q[g] <= lookAddr;
            end
         end
      end
   endgenerate

   // Priority encoders, lowest index wins
   always_comb begin
      hit       = 1'b0;
      hitIdx    = 4'h0;
      freeAvail = 1'b0;
      freeIdx   = 4'h0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (matchVec[i]) begin
            hit    = 1'b1;
            hitIdx = 4'(i);
         end
         if (!used_q[i]) begin
            freeAvail = 1'b1;
            freeIdx   = 4'(i);
         end
      end
   end

   assign usedMap = used_q;
endmodule : trib_slot_table

// ### sim/trib_host_model.sv
// Purpose: Host software model that delivers control commands to the decoder
// Assumes: One command per call; fields held through the edge that takes them
// Notes:   Released fields go to their inverse so stale bytes never look fresh
`timescale 1ns/1ps
module trib_host_model (
   input  wire logic core_clk,
   output logic      cmdValid,
   output logic [2:0]  requestKey,
   output logic [7:0]  tributaryAddressByte,
   output logic [7:0]  commandParameterByte,
   output logic [15:0] controlFlagByte
);
   import trib_cmd_pkg::*;
   // Idle at time zero, nothing offered
   initial begin
      cmdValid = 1'b0;
      requestKey = KEY_NULL;
      tributaryAddressByte = 8'h00;
      commandParameterByte = 8'h00;
      controlFlagByte = 16'h0000;
   end
   // One command: raise after an edge, hold through the taking edge, release
   task automatic send(input logic [2:0] k, input logic [7:0] a, input logic [7:0] p, input logic [15:0] f);
      @(posedge core_clk);
      cmdValid <= 1'b1;
      requestKey <= k;
      tributaryAddressByte <= a;
      commandParameterByte <= p;
      controlFlagByte <= f;
      @(posedge core_clk);
      cmdValid <= 1'b0;
      requestKey <= ~k;
      tributaryAddressByte <= ~a;
      commandParameterByte <= ~p;
      controlFlagByte <= ~f;
   endtask : send
   // Flag-only work goes out under the null key, never a real request
   task automatic flags_only(input logic [7:0] a, input logic [7:0] p, input logic [15:0] f);
      send(KEY_NULL, a, p, f);
   endtask : flags_only
endmodule : trib_host_model

// ### sim/test_tributary_control_command_decoder.sv
// Purpose: Self-checking bench for the tributary control command decoder
// Assumes: Default twelve slots; slot bytes are only cleared, never written here
// Notes:   Outputs are sampled 1 ns after an edge so that edge's updates have landed
`timescale 1ns/1ps
module test_tributary_control_command_decoder;
   import trib_cmd_pkg::*;
   logic core_clk, rst_n, cmdValid, cmdDone, procError, unknownKey, globalSlotValid;
   logic [2:0]  requestKey;
   logic [7:0]  tributaryAddressByte, commandParameterByte, statusByte;
   logic [15:0] controlFlagByte;
   logic [3:0]  statusSlotSel;
   logic [5:0]  statusLocSel;
   logic [11:0] slotUsed, pollLatched, poolEnabled;
   logic [23:0] pollState;
   int          failures, n_checks;
   localparam logic [15:0] LAT = 16'h0001 << FLAG_LATCH;
   localparam logic [15:0] UNL = 16'h0001 << FLAG_UNLATCH;
   // ----------------------------------------
   // Harness
   // ----------------------------------------
   trib_host_model host (.core_clk(core_clk), .cmdValid(cmdValid), .requestKey(requestKey),
      .tributaryAddressByte(tributaryAddressByte), .commandParameterByte(commandParameterByte),
      .controlFlagByte(controlFlagByte));
   trib_cmd_decoder DUT (.core_clk(core_clk), .rst_n(rst_n), .cmdValid(cmdValid), .requestKey(requestKey),
      .tributaryAddressByte(tributaryAddressByte), .commandParameterByte(commandParameterByte),
      .controlFlagByte(controlFlagByte), .statusSlotSel(statusSlotSel), .statusLocSel(statusLocSel),
      .cmdDone(cmdDone), .procError(procError), .unknownKey(unknownKey), .globalSlotValid(globalSlotValid),
      .slotUsed(slotUsed), .pollState(pollState), .pollLatched(pollLatched), .poolEnabled(poolEnabled),
      .statusByte(statusByte));
   // 125 MHz clock
   initial core_clk = 1'b0;
   always #4 core_clk = ~core_clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   // Issue a command, judge the pulses while they stand, then let the mirrors settle
   task automatic cmd(input logic [2:0] k, input logic [7:0] a, input logic [7:0] p, input logic [15:0] f,
                      input logic err);
      host.send(k, a, p, f);
      #1;
      check(cmdDone, 1'b1);
      check(procError, err);
      check(unknownKey, 1'((k != KEY_NULL) && (k != KEY_ESTABLISH)));
      @(posedge core_clk);
      #1;
      check(cmdDone, 1'b0);
   endtask : cmd
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_establish;
      cmd(KEY_ESTABLISH, 8'h05, 8'h03, LAT, 1'b0);
      check(slotUsed, 12'h001);
      check(globalSlotValid, 1'b1);
      check(pollState, 24'h000003);
      check(pollLatched, 12'h001);
      check(statusByte, 8'h00);
      cmd(KEY_ESTABLISH, 8'h05, 8'h00, 16'h0000, 1'b0);
      check(slotUsed, 12'h001);
      check(pollState, 24'h000003);
      cmd(3'h2, 8'h05, 8'h00, 16'h0000, 1'b0);
      check(slotUsed, 12'h001);
      $display("establish test done");
   endtask : t_establish
   task automatic t_codes;
      for (int v = 0; v < 4; v++) begin
         host.flags_only(8'h05, 8'(v), LAT);
         repeat (2) @(posedge core_clk);
         #1;
         check(pollState, 24'(v));
      end
      cmd(KEY_NULL, 8'h05, 8'h02, UNL, 1'b0);
      check(pollState, 24'h000000);
      check(pollLatched, 12'h000);
      $display("polling state test done");
   endtask : t_codes
   task automatic t_pool;
      cmd(KEY_NULL, 8'h05, 8'h01, 16'h0001 << FLAG_POOL_EN, 1'b0);
      check(poolEnabled, 12'h001);
      cmd(KEY_NULL, 8'h05, 8'h00, 16'h0001 << FLAG_POOL_DIS, 1'b0);
      check(poolEnabled, 12'h000);
      cmd(KEY_NULL, 8'h77, 8'h02, LAT, 1'b0);
      check(pollState, 24'h000000);
      check(slotUsed, 12'h001);
      $display("pool and address test done");
   endtask : t_pool
   task automatic t_full;
      for (int i = 1; i < SLOT_COUNT; i++) begin
         cmd(KEY_ESTABLISH, (i == 1) ? 8'h01 : 8'(8'h10 + i), 8'h00, 16'h0000, 1'b0);
      end
      check(slotUsed, 12'hFFF);
      cmd(KEY_ESTABLISH, 8'h40, 8'h01, LAT, 1'b1);
      check(slotUsed, 12'hFFF);
      check(pollLatched, 12'h000);
      $display("slot exhaustion test done");
   endtask : t_full
   // Main sequence: reset for 16 cycles, then the scenarios
   initial begin
      failures = 0;
      n_checks = 0;
      rst_n = 1'b0;
      statusSlotSel = 4'h0;
      statusLocSel = 6'h3F;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      check(slotUsed, 12'h000);
      check(globalSlotValid, 1'b0);
      t_establish();
      t_codes();
      t_pool();
      t_full();
      end_sim();
   end
   // Watchdog well beyond the fewer than a hundred cycles the scenarios need
   initial begin
      #200000;
      failures++;
      end_sim();
   end
endmodule : test_tributary_control_command_decoder
